// >>> cwmp_pkg.sv
// Package for the memory-partition configuration word decoder.
package cwmp_pkg;

	localparam logic [15:0] CWMP_ADDR_RSVD   = 16'h8009;
	localparam logic [15:0] CWMP_ADDR_CFG4   = 16'h800a;
	localparam logic [15:0] CWMP_CFG4_RESET  = 16'h2fbf;
	localparam logic [15:0] CWMP_CFG4_MASK   = 16'h2b9f;
	localparam int          CWMP_LOWV_BIT    = 13;
	localparam int          CWMP_WRSAF_BIT   = 11;
	localparam int          CWMP_WRCFG_BIT   = 9;
	localparam int          CWMP_WRBOOT_BIT  = 8;
	localparam int          CWMP_WRAPP_BIT   = 7;
	localparam int          CWMP_SFEN_BIT    = 4;
	localparam int          CWMP_BREN_BIT    = 3;
	localparam int          CWMP_SIZE_LSB    = 0;
	localparam logic [15:0] CWMP_PROT_MASK   = 16'h0b80;
	localparam logic [14:0] CWMP_END_512     = 15'h01ff;
	localparam logic [14:0] CWMP_END_1K      = 15'h03ff;
	localparam logic [14:0] CWMP_END_2K      = 15'h07ff;
	localparam logic [14:0] CWMP_END_4K      = 15'h0fff;
	localparam logic [14:0] CWMP_END_8K      = 15'h1fff;
	localparam logic [14:0] CWMP_END_16K     = 15'h3fff;
	localparam logic [14:0] CWMP_PFM_WORDS   = 15'h0800;
	localparam logic [14:0] CWMP_SF_START    = 15'h0780;
	localparam logic [14:0] CWMP_PFM_TOP     = 15'h07ff;

	// Decoded controls derived from the configuration word.
	typedef struct packed {
		logic        lowVoltProgEnable;
		logic        storageFlashWriteProtect;
		logic        configWriteProtect;
		logic        bootRegionWriteProtect;
		logic        applicationRegionWriteProtect;
		logic        storageFlashEnable;
		logic        bootRegionEnable;
		logic [14:0] bootEndAddr;
	} cwmp_ctrl_t;

	// Write or erase request from the programmer or self-write path.
	typedef struct packed {
		logic        valid;
		logic        isConfig;
		logic        bulkErase;
		logic        lowVoltSession;
		logic [15:0] addr;
		logic [15:0] data;
	} cwmp_req_t;

endpackage : cwmp_pkg

// >>> cwmp_size_decode.sv
// Boot-region size decoder with the half-memory cap.
`timescale 1ns/1ps
module cwmp_size_decode
	import cwmp_pkg::*;
(
	input  wire logic [2:0]  bootRegionSize,
	output logic      [14:0] bootEndAddr
);

	logic [14:0] rawEnd;
	logic [14:0] halfEnd;

	// Table lookup of the end address; low codes all share the largest size.
	assign rawEnd = (bootRegionSize == 3'h7) ? CWMP_END_512 :
	                (bootRegionSize == 3'h6) ? CWMP_END_1K :
	                (bootRegionSize == 3'h5) ? CWMP_END_2K :
	                (bootRegionSize == 3'h4) ? CWMP_END_4K :
	                (bootRegionSize == 3'h3) ? CWMP_END_8K : CWMP_END_16K;

	// Any code beyond half of program memory collapses to exactly half.
	assign halfEnd     = (CWMP_PFM_WORDS >> 1) - 15'h0001;
	assign bootEndAddr = (rawEnd > halfEnd) ? halfEnd : rawEnd;

endmodule : cwmp_size_decode

// >>> cwmp_config_word.sv
// Memory-partition configuration word: storage, decode and write guarding.
`timescale 1ns/1ps
//
// Contract
// - Low-voltage enable set enables low-voltage programming and forces master clear.
// - Refuse clearing low-voltage enable during a low-voltage programming session.
// - Bit 11 low protects storage flash, only while storage flash is enabled.
// - Bit 9 low protects the configuration words.
// - Bit 8 low protects the boot block, only while the boot block is enabled.
// - Bit 7 low protects the application block.
// - Once set, protection is removed only by bulk erase.
// - Bit 4 low enables the storage flash region.
// - Bit 3 low enables the boot block; size is don't-care when disabled.
// - Size codes 111, 110, 101 give ends 01FFh, 03FFh, 07FFh.
// - Codes 100 give 0FFFh, 011 gives 1FFFh, lower codes 3FFFh.
// - Size changes only while boot block disabled, else only by bulk erase.
// - Boot block is capped at half of program memory.
// - The word at 0x8009 is reserved and has no effect.
// - Low-voltage enable off and master-clear enable low give the port function.
module cwmp_config_word
	import cwmp_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire cwmp_req_t  req,
	input  wire logic       masterClearPinEnable,
	output logic            reqAccept,
	output logic            reqBlocked,
	output logic [15:0]     configWord,
	output cwmp_ctrl_t      ctrl,
	output logic            pinIsMasterClear
);

	////////////////////////////////////////////////////////////////////////////
	// Word storage and write qualification.

	logic [15:0] cfgWord_r;
	logic [15:0] cfgWord_nxt;
	logic [15:0] wrData;
	logic [14:0] bootEnd;
	logic        hitCfg4;
	logic        lowVoltDrop;
	logic        protLoosen;
	logic        sizeLocked;
	logic        cfgWrite;
	logic        memWrite;
	logic        inBoot;
	logic        inStore;
	logic        inApp;
	logic        memProtected;

	assign hitCfg4 = req.isConfig && (req.addr == CWMP_ADDR_CFG4);
	assign wrData  = (req.data & CWMP_CFG4_MASK) | (CWMP_CFG4_RESET & ~CWMP_CFG4_MASK);
	// Clearing the low-voltage enable during a low-voltage session would strand the programmer.
	assign lowVoltDrop = req.lowVoltSession && cfgWord_r[CWMP_LOWV_BIT] && !wrData[CWMP_LOWV_BIT];
	// Any protect bit going from 0 back to 1 is an attempt to remove protection.
	assign protLoosen = |(~cfgWord_r & wrData & CWMP_PROT_MASK);
	// Size is frozen once the boot block is enabled.
	assign sizeLocked = !cfgWord_r[CWMP_BREN_BIT]
	                    && (wrData[2:0] != cfgWord_r[2:0]);
	// A config write also needs config protection off; the reserved word is ignored.
	assign cfgWrite = req.valid && !req.bulkErase && hitCfg4 && cfgWord_r[CWMP_WRCFG_BIT]
	                  && !lowVoltDrop && !protLoosen && !sizeLocked;

	// Region membership for program memory writes.
	assign inBoot = ctrl.bootRegionEnable && (req.addr[14:0] <= bootEnd);
	assign inStore = ctrl.storageFlashEnable && (req.addr[14:0] >= CWMP_SF_START)
	                 && (req.addr[14:0] <= CWMP_PFM_TOP);
	assign inApp  = !inBoot && !inStore;
	assign memProtected = (inBoot && ctrl.bootRegionWriteProtect)
	                      || (inStore && ctrl.storageFlashWriteProtect)
	                      || (inApp && ctrl.applicationRegionWriteProtect);
	assign memWrite = req.valid && !req.isConfig && !req.bulkErase && !memProtected;

	// Bulk erase returns the word to its erased state, lifting every lock.
	assign cfgWord_nxt = (req.valid && req.bulkErase) ? CWMP_CFG4_RESET :
	                     cfgWrite ? wrData : cfgWord_r;

	// Handshake outcome for the current request.
	assign reqAccept  = (req.valid && req.bulkErase) || cfgWrite || memWrite
	                    || (req.valid && req.isConfig && !hitCfg4);
	assign reqBlocked = req.valid && !reqAccept;

	// Short storage process; the erased value is the reset value.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cfgWord_r <= CWMP_CFG4_RESET;
		end else begin
			cfgWord_r <= cfgWord_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decoded controls.

	cwmp_size_decode u_size (
		.bootRegionSize (cfgWord_r[2:0]),
		.bootEndAddr    (bootEnd)
	);

	assign configWord = cfgWord_r;
	assign ctrl.lowVoltProgEnable   = cfgWord_r[CWMP_LOWV_BIT];
	assign ctrl.storageFlashEnable  = !cfgWord_r[CWMP_SFEN_BIT];
	assign ctrl.bootRegionEnable    = !cfgWord_r[CWMP_BREN_BIT];
	// Storage and boot protection only matter while their regions exist.
	assign ctrl.storageFlashWriteProtect = ctrl.storageFlashEnable && !cfgWord_r[CWMP_WRSAF_BIT];
	assign ctrl.configWriteProtect       = !cfgWord_r[CWMP_WRCFG_BIT];
	assign ctrl.bootRegionWriteProtect   = ctrl.bootRegionEnable && !cfgWord_r[CWMP_WRBOOT_BIT];
	assign ctrl.applicationRegionWriteProtect = !cfgWord_r[CWMP_WRAPP_BIT];
	// End address is zero when the boot block is absent, since size is then meaningless.
	assign ctrl.bootEndAddr = ctrl.bootRegionEnable ? bootEnd : 15'h0000;
	// Low-voltage enable overrides the pin enable; otherwise the enable picks master clear or port.
	assign pinIsMasterClear = cfgWord_r[CWMP_LOWV_BIT] || masterClearPinEnable;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	chk_lvp_hold: assert property (@(posedge mclk) disable iff (reset)
		(req.valid && req.lowVoltSession && !req.bulkErase && cfgWord_r[CWMP_LOWV_BIT])
		|=> cfgWord_r[CWMP_LOWV_BIT])
		else $error("Low-voltage enable cleared during low-voltage session");

	chk_prot_sticky: assert property (@(posedge mclk) disable iff (reset)
		(!cfgWord_r[CWMP_WRAPP_BIT] && !(req.valid && req.bulkErase)) |=> !cfgWord_r[CWMP_WRAPP_BIT])
		else $error("Application protection removed without bulk erase");

	chk_erase_clears: assert property (@(posedge mclk) disable iff (reset)
		(req.valid && req.bulkErase) |=> (cfgWord_r == CWMP_CFG4_RESET))
		else $error("Bulk erase did not restore the word");

	chk_size_frozen: assert property (@(posedge mclk) disable iff (reset)
		(!cfgWord_r[CWMP_BREN_BIT] && !(req.valid && req.bulkErase)) |=> $stable(cfgWord_r[2:0]))
		else $error("Boot size changed while boot block enabled");

	chk_cfg_protect: assert property (@(posedge mclk) disable iff (reset)
		(ctrl.configWriteProtect && !(req.valid && req.bulkErase)) |=> $stable(cfgWord_r))
		else $error("Config word changed while protected");

	chk_boot_block: assert property (@(posedge mclk) disable iff (reset)
		(req.valid && !req.isConfig && !req.bulkErase && ctrl.bootRegionWriteProtect
		 && req.addr[14:0] <= ctrl.bootEndAddr) |-> reqBlocked)
		else $error("Write to protected boot block accepted");

	chk_pin_mclr: assert property (@(posedge mclk) disable iff (reset)
		cfgWord_r[CWMP_LOWV_BIT] |-> pinIsMasterClear)
		else $error("Pin not master clear with low-voltage enable set");

	chk_pin_port: assert property (@(posedge mclk) disable iff (reset)
		(!cfgWord_r[CWMP_LOWV_BIT] && !masterClearPinEnable) |-> !pinIsMasterClear)
		else $error("Pin not port function");

	chk_size_cap: assert property (@(posedge mclk) disable iff (reset)
		ctrl.bootRegionEnable |-> (ctrl.bootEndAddr <= CWMP_END_1K))
		else $error("Boot block exceeds half of memory");

	////////////////////////////////////////////////////////////////////////////
	// Further checks on refusals, sticky protection and the size table.
	// Except chk_app_block (inApp) and chk_lowv_refuse, chk_cfg_refuse (hitCfg4), they compare against package constants so a broken decode shows here.

	chk_store_block: assert property (@(posedge mclk) disable iff (reset)
		(req.valid && !req.isConfig && !req.bulkErase && ctrl.storageFlashWriteProtect
		 && req.addr[14:0] >= CWMP_SF_START && req.addr[14:0] <= CWMP_PFM_TOP
		 && !(ctrl.bootRegionEnable && req.addr[14:0] <= ctrl.bootEndAddr)) |-> reqBlocked)
		else $error("Write to protected storage flash accepted");

	chk_app_block: assert property (@(posedge mclk) disable iff (reset)
		(req.valid && !req.isConfig && !req.bulkErase && inApp
		 && ctrl.applicationRegionWriteProtect) |-> reqBlocked)
		else $error("Write to protected application block accepted");

	chk_lowv_refuse: assert property (@(posedge mclk) disable iff (reset)
		(req.valid && hitCfg4 && !req.bulkErase && req.lowVoltSession
		 && cfgWord_r[CWMP_LOWV_BIT] && !req.data[CWMP_LOWV_BIT]) |-> reqBlocked)
		else $error("Low-voltage enable clear accepted in session");

	chk_cfg_refuse: assert property (@(posedge mclk) disable iff (reset)
		(req.valid && hitCfg4 && !req.bulkErase && ctrl.configWriteProtect) |-> reqBlocked)
		else $error("Config write accepted while protected");

	chk_rsvd_ignored: assert property (@(posedge mclk) disable iff (reset)
		(req.valid && req.isConfig && !req.bulkErase && req.addr == CWMP_ADDR_RSVD)
		|=> $stable(cfgWord_r))
		else $error("Reserved word write changed the config word");

	chk_store_sticky: assert property (@(posedge mclk) disable iff (reset)
		(!cfgWord_r[CWMP_WRSAF_BIT] && !(req.valid && req.bulkErase)) |=> !cfgWord_r[CWMP_WRSAF_BIT])
		else $error("Storage protection removed without bulk erase");

	chk_cfgp_sticky: assert property (@(posedge mclk) disable iff (reset)
		(!cfgWord_r[CWMP_WRCFG_BIT] && !(req.valid && req.bulkErase)) |=> !cfgWord_r[CWMP_WRCFG_BIT])
		else $error("Config protection removed without bulk erase");

	chk_boot_sticky: assert property (@(posedge mclk) disable iff (reset)
		(!cfgWord_r[CWMP_WRBOOT_BIT] && !(req.valid && req.bulkErase)) |=> !cfgWord_r[CWMP_WRBOOT_BIT])
		else $error("Boot protection removed without bulk erase");

	chk_size_small: assert property (@(posedge mclk) disable iff (reset)
		(ctrl.bootRegionEnable && cfgWord_r[2:0] == 3'h7) |-> (ctrl.bootEndAddr == CWMP_END_512))
		else $error("Smallest boot size has wrong end address");

	chk_size_large: assert property (@(posedge mclk) disable iff (reset)
		(ctrl.bootRegionEnable && cfgWord_r[2:0] != 3'h7) |-> (ctrl.bootEndAddr == CWMP_END_1K))
		else $error("Larger boot size not held at half of memory");

	chk_boot_off: assert property (@(posedge mclk) disable iff (reset)
		!ctrl.bootRegionEnable |-> (ctrl.bootEndAddr == 15'h0000))
		else $error("End address shown while boot block disabled");

	chk_erase_accept: assert property (@(posedge mclk) disable iff (reset)
		(req.valid && req.bulkErase) |-> reqAccept)
		else $error("Bulk erase refused");

endmodule : cwmp_config_word

// >>> cwmp_prog_model.sv
// Programmer model that issues word write and erase requests.
`timescale 1ns/1ps
module cwmp_prog_model
	import cwmp_pkg::*;
(
	input  wire logic mclk,
	input  wire logic reqAccept,
	output cwmp_req_t req
);
	initial req = '0;
	// One request per call, held up to the sampling edge and released on it.
	task automatic send(input logic cfg, input logic bulk, input logic lv,
		input logic [15:0] a, input logic [15:0] d, output logic acc);
		@(posedge mclk);
		#1 req = '{1'b1, cfg, bulk, lv, a, d};
		@(posedge mclk);
		acc = reqAccept;
		req <= '0;
	endtask : send
endmodule : cwmp_prog_model

// >>> cwmp_config_word_tb.sv
// Self-checking bench for the configuration word decoder.
`timescale 1ns/1ps
module cwmp_config_word_tb
	import cwmp_pkg::*;
;
	logic        mclk, reset, mce, acc, reqAccept, reqBlocked, pinIsMasterClear;
	logic [15:0] configWord;
	cwmp_req_t   req;
	cwmp_ctrl_t  ctrl;
	int          failCount = 0;
	int          comparisons = 0;
	cwmp_prog_model i_prog (.mclk(mclk), .reqAccept(reqAccept), .req(req));
	cwmp_config_word i_dut (.mclk(mclk), .reset(reset), .req(req), .masterClearPinEnable(mce),
		.reqAccept(reqAccept), .reqBlocked(reqBlocked), .configWord(configWord), .ctrl(ctrl),
		.pinIsMasterClear(pinIsMasterClear));
	////////////////////////////////////////
	// Shared comparison, closing report and request helpers.
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failCount++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize;
		$display("checks %0d mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic cfg(input logic [15:0] d, input logic lv, input logic ok);
		i_prog.send(1'b1, 1'b0, lv, CWMP_ADDR_CFG4, d, acc);
		check("accept", acc, ok);
		#1;
	endtask : cfg
	task automatic mem(input logic [15:0] a, input logic ok);
		i_prog.send(1'b0, 1'b0, 1'b0, a, 16'h1234, acc);
		check("mem accept", acc, ok);
	endtask : mem
	task automatic erase;
		i_prog.send(1'b1, 1'b1, 1'b0, CWMP_ADDR_CFG4, 16'h0000, acc);
		check("erase accept", acc, 1'b1);
		#1;
	endtask : erase
	////////////////////////////////////////
	// Scenarios; the erased word is the starting point of each.
	task automatic t_size;
		for (int c = 0; c < 8; c++) begin
			erase();
			check("off end", ctrl.bootEndAddr, 15'h0000);
			cfg(16'h2fb0 | 16'(c), 1'b0, 1'b1);
			check("end", ctrl.bootEndAddr, (c == 7) ? CWMP_END_512 : CWMP_END_1K);
		end
		cfg(16'h2fb6, 1'b0, 1'b0);
		check("end kept", ctrl.bootEndAddr, CWMP_END_512);
		$display("size done");
	endtask : t_size
	task automatic t_prot;
		erase();
		cfg(16'h2f3f, 1'b0, 1'b1);
		check("app wp", ctrl.applicationRegionWriteProtect, 1'b1);
		mem(16'h0100, 1'b0);
		cfg(16'h2fbf, 1'b0, 1'b0);
		erase();
		check("erased", configWord, CWMP_CFG4_RESET);
		mem(16'h0100, 1'b1);
		cfg(16'h2dbf, 1'b0, 1'b1);
		check("cfg wp", ctrl.configWriteProtect, 1'b1);
		cfg(16'h2dbe, 1'b0, 1'b0);
		check("cfg kept", configWord, 16'h2dbf);
		$display("protect done");
	endtask : t_prot
	task automatic t_region;
		erase();
		cfg(16'h27bf, 1'b0, 1'b1);
		mem(16'h0780, 1'b1);
		erase();
		cfg(16'h27af, 1'b0, 1'b1);
		check("store on", ctrl.storageFlashEnable, 1'b1);
		mem(16'h0780, 1'b0);
		erase();
		cfg(16'h2eb7, 1'b0, 1'b1);
		check("boot wp", ctrl.bootRegionWriteProtect, 1'b1);
		mem(16'h0100, 1'b0);
		mem(16'h0300, 1'b1);
		$display("region done");
	endtask : t_region
	task automatic t_pin;
		erase();
		check("pin lowv", pinIsMasterClear, 1'b1);
		cfg(16'h0fbf, 1'b1, 1'b0);
		cfg(16'h0fbf, 1'b0, 1'b1);
		check("pin port", pinIsMasterClear, 1'b0);
		mce = 1'b1;
		#1 check("pin mclr", pinIsMasterClear, 1'b1);
		erase();
		i_prog.send(1'b1, 1'b0, 1'b0, CWMP_ADDR_RSVD, 16'h0000, acc);
		#1 check("rsvd", configWord, CWMP_CFG4_RESET);
		$display("pin done");
	endtask : t_pin
	////////////////////////////////////////
	// Clock, a cycle limit against hangs, and the main sequence.
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		failCount++;
		summarize();
	end
	initial begin
		reset = 1'b1;
		mce = 1'b0;
		repeat (5) @(posedge mclk);
		#1 reset = 1'b0;
		check("reset", configWord, CWMP_CFG4_RESET);
		t_size();
		t_prot();
		t_region();
		t_pin();
		summarize();
	end
endmodule : cwmp_config_word_tb
